// *** autopoll_defines.svh ***
// constants for the auto-poll receiver control block
// assumes a single 40 MHz core clock; included by the package and the checker
`ifndef AUTOPOLL_DEFINES_SVH
`define AUTOPOLL_DEFINES_SVH

`define CFG_WIDTH 20
`define CFG_RESET_VALUE 20'h02e78
`define CFG_BIT_AGC_SLOW 19
`define CFG_BIT_WDOG_OFF 18
`define CFG_BIT_TEST 17
`define CFG_BIT_HIGH_BW 16
`define CFG_BIT_AUTOPOLL 15
`define CFG_SLEEP_HI 14
`define CFG_SLEEP_LO 12
`define CFG_WIN_HI 11
`define CFG_WIN_LO 9
`define CFG_VALID_HI 8
`define CFG_VALID_LO 7
`define CFG_SLICE_HI 6
`define CFG_SLICE_LO 5
`define CFG_BW_HI 4
`define CFG_BW_LO 3

`define CLK_MHZ 40
`define SLEEP_BASE_MS 10
`define SCLK_MIN_HZ 5000
`define BAD_BITS_TO_SLEEP 4

// widest-bandwidth bit-check windows in microseconds, code 000 to 111
`define WIN_US_0 71
`define WIN_US_1 67
`define WIN_US_2 62
`define WIN_US_3 57
`define WIN_US_4 52
`define WIN_US_5 48
`define WIN_US_6 43
`define WIN_US_7 38

`endif

// *** autopoll_pkg.sv ***
// types shared by the auto-poll receiver control block
// assumes autopoll_defines.svh is on the include path
`include "autopoll_defines.svh"

package autopoll_pkg;

	typedef enum logic [1:0] {POLL_AWAKE, POLL_SLEEP, POLL_CHECK, POLL_RECEIVE} pollState_t;

	typedef enum logic [2:0] {SER_IDLE, SER_ARMED, SER_CLKLOW, SER_CLKHIGH, SER_MARK,
		SER_SHIFT, SER_STOPMARK, SER_STOPEND} serState_t;

	typedef struct packed {
		logic sclkMeta;
		logic sclkSync;
		logic sclkPrev;
		logic dinMeta;
		logic dinSync;
		logic dinPrev;
		logic slicedMeta;
		logic slicedSync;
		logic slicedPrev;
		serState_t serState;
		logic [`CFG_WIDTH-1:0] shiftReg;
		logic [4:0] bitCount;
		logic [15:0] serIdle;
		logic [`CFG_WIDTH-1:0] activeCfg;
		pollState_t pollState;
		logic [31:0] sleepLeft;
		logic [15:0] runLen;
		logic [3:0] validCnt;
		logic [2:0] badCnt;
		logic doOut;
		logic doOe;
		logic sleepMode;
		logic checking;
	} state_t;

endpackage

// *** autopoll_bitcheck_serial_config.sv ***
// auto-poll sequencer, bit checker and two-wire configuration loader
// assumes sclk, the shared data pin and the sliced data arrive unsynchronised;
// the pad ring resolves the data pin from dataPinOut and dataPinOe
//
// Notes on behaviour
// - auto-poll bit set: search, data held low
// - alternate sleep and polling with checking
// - sleep 10ms doubled per code step
// - run longer than window valid, else bad
// - window from code, doubled per bandwidth halving
// - valid-bit count field: 0, 2, 4, 8
// - hold data low; four bad bits sleep
// - release after valid run, stay receiving
// - twenty-bit word loaded only over serial
// - clock high releases data pin to host
// - slow serial clock resets the loader
// - bits shift in most significant first
// - short load updates only low bits
// - stop pulse ends load, pin driven again
// - pin becomes input within 0.1us
// - bit19 low fast attack; bit18 watchdog off
// - slice field selects slicing level

module autopoll_bitcheck_serial_config #(
	parameter int unsigned SleepBaseCycles = `SLEEP_BASE_MS * `CLK_MHZ * 1000,
	parameter int unsigned SclkTimeoutCycles = (1000000 / `SCLK_MIN_HZ) * `CLK_MHZ
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclkPin,
	input wire logic dataPinIn,
	output logic dataPinOut,
	output logic dataPinOe,
	input wire logic slicedData,
	output logic [`CFG_WIDTH-1:0] configWord,
	output logic sleepMode,
	output logic checkingBits,
	output logic agcFastAttackEn,
	output logic watchdogEn,
	output logic [1:0] sliceLevel,
	output logic highBandwidth,
	output logic [1:0] demodBandwidth
);
	import autopoll_pkg::*;

	state_t cur_reg;
	state_t cur_next;

	function automatic logic [15:0] windowCycles(input logic [2:0] code, input logic [1:0] bw);
		logic [15:0] base;
		base = 16'h0000;
		unique case (code)
			3'h0: base = 16'(`WIN_US_0 * `CLK_MHZ);
			3'h1: base = 16'(`WIN_US_1 * `CLK_MHZ);
			3'h2: base = 16'(`WIN_US_2 * `CLK_MHZ);
			3'h3: base = 16'(`WIN_US_3 * `CLK_MHZ);
			3'h4: base = 16'(`WIN_US_4 * `CLK_MHZ);
			3'h5: base = 16'(`WIN_US_5 * `CLK_MHZ);
			3'h6: base = 16'(`WIN_US_6 * `CLK_MHZ);
			3'h7: base = 16'(`WIN_US_7 * `CLK_MHZ);
		endcase
		// each halving of bandwidth doubles the window
		return base << (2'h3 - bw);
	endfunction

	function automatic logic [3:0] requiredValid(input logic [1:0] code);
		logic [3:0] n;
		n = 4'h0;
		unique case (code)
			2'h0: n = 4'h0;
			2'h1: n = 4'h2;
			2'h2: n = 4'h4;
			2'h3: n = 4'h8;
		endcase
		return n;
	endfunction

	function automatic logic [31:0] sleepCycles(input logic [2:0] code);
		return SleepBaseCycles << code;
	endfunction

	logic [`CFG_WIDTH-1:0] loadMask;
	logic [`CFG_WIDTH-1:0] mergedCfg;
	logic commit;
	logic sclkRise;
	logic sclkFall;
	logic dinRise;
	logic dinFall;
	logic slicedEdge;
	logic [15:0] window;
	logic runValid;

	always_comb
	begin
		cur_next = cur_reg;
		commit = 1'b0;
		loadMask = '0;
		mergedCfg = cur_reg.activeCfg;

		cur_next.sclkMeta = sclkPin;
		cur_next.sclkSync = cur_reg.sclkMeta;
		cur_next.sclkPrev = cur_reg.sclkSync;
		cur_next.dinMeta = dataPinIn;
		cur_next.dinSync = cur_reg.dinMeta;
		cur_next.dinPrev = cur_reg.dinSync;
		cur_next.slicedMeta = slicedData;
		cur_next.slicedSync = cur_reg.slicedMeta;
		cur_next.slicedPrev = cur_reg.slicedSync;

		sclkRise = cur_reg.sclkSync & ~cur_reg.sclkPrev;
		sclkFall = ~cur_reg.sclkSync & cur_reg.sclkPrev;
		dinRise = cur_reg.dinSync & ~cur_reg.dinPrev;
		dinFall = ~cur_reg.dinSync & cur_reg.dinPrev;
		slicedEdge = cur_reg.slicedSync ^ cur_reg.slicedPrev;

		// watchdog on the serial clock: any edge restarts it
		if (sclkRise || sclkFall || cur_reg.serState == SER_IDLE)
			cur_next.serIdle = 16'h0000;
		else if (cur_reg.serIdle != 16'hffff)
			cur_next.serIdle = cur_reg.serIdle + 16'h0001;

		unique case (cur_reg.serState)
			SER_IDLE:
			begin
				if (cur_reg.sclkSync)
					cur_next.serState = SER_ARMED;
			end
			SER_ARMED:
			begin
				if (sclkFall)
					cur_next.serState = SER_CLKLOW;
			end
			SER_CLKLOW:
			begin
				if (sclkRise && !cur_reg.dinSync)
					cur_next.serState = SER_CLKHIGH;
			end
			SER_CLKHIGH:
			begin
				if (sclkFall)
					cur_next.serState = SER_CLKLOW;
				else if (dinRise)
					cur_next.serState = SER_MARK;
			end
			SER_MARK:
			begin
				if (sclkFall)
					cur_next.serState = SER_CLKLOW;
				else if (dinFall)
				begin
					cur_next.serState = SER_SHIFT;
					cur_next.shiftReg = '0;
					cur_next.bitCount = 5'h00;
				end
			end
			SER_SHIFT:
			begin
				if (sclkRise)
				begin
					// msb arrives first, so each new bit enters at the bottom
					cur_next.shiftReg = {cur_reg.shiftReg[`CFG_WIDTH-2:0], cur_reg.dinSync};
					if (cur_reg.bitCount != 5'(`CFG_WIDTH))
						cur_next.bitCount = cur_reg.bitCount + 5'h01;
				end
				else if (cur_reg.sclkSync && dinRise)
					cur_next.serState = SER_STOPMARK;
			end
			SER_STOPMARK:
			begin
				if (dinFall)
				begin
					cur_next.serState = SER_STOPEND;
					commit = 1'b1;
				end
				else if (sclkFall)
					cur_next.serState = SER_SHIFT;
			end
			SER_STOPEND:
			begin
				if (!cur_reg.sclkSync)
					cur_next.serState = SER_IDLE;
			end
		endcase

		// a clock with no edge for one full period of the minimum rate abandons any load in progress
		if (cur_reg.serState != SER_IDLE && cur_reg.serIdle >= 16'(SclkTimeoutCycles))
			cur_next.serState = SER_IDLE;

		// only the bits actually clocked in are replaced, all at once
		for (int i = 0; i < `CFG_WIDTH; i++)
			loadMask[i] = (5'(i) < cur_reg.bitCount);
		mergedCfg = (cur_reg.activeCfg & ~loadMask) | (cur_reg.shiftReg & loadMask);
		if (commit)
			cur_next.activeCfg = mergedCfg;

		// data pin is released as soon as the synchronised clock is high
		cur_next.doOe = (cur_next.serState == SER_IDLE) && !cur_reg.sclkSync;

		window = windowCycles(cur_reg.activeCfg[`CFG_WIN_HI:`CFG_WIN_LO],
			cur_reg.activeCfg[`CFG_BW_HI:`CFG_BW_LO]);
		runValid = cur_reg.runLen > window;

		unique case (cur_reg.pollState)
			POLL_AWAKE:
			begin
				cur_next.runLen = 16'h0000;
			end
			POLL_SLEEP:
			begin
				if (cur_reg.sleepLeft != 32'h00000000)
					cur_next.sleepLeft = cur_reg.sleepLeft - 32'h00000001;
				else
				begin
					cur_next.pollState = POLL_CHECK;
					cur_next.runLen = 16'h0000;
					cur_next.validCnt = 4'h0;
					cur_next.badCnt = 3'h0;
				end
			end
			POLL_CHECK:
			begin
				if (cur_reg.validCnt >= requiredValid(cur_reg.activeCfg[`CFG_VALID_HI:`CFG_VALID_LO]))
					cur_next.pollState = POLL_RECEIVE;
				else if (slicedEdge)
				begin
					cur_next.runLen = 16'h0000;
					if (runValid)
					begin
						cur_next.validCnt = cur_reg.validCnt + 4'h1;
						cur_next.badCnt = 3'h0;
					end
					else if (cur_reg.badCnt == 3'(`BAD_BITS_TO_SLEEP - 1))
					begin
						cur_next.pollState = POLL_SLEEP;
						cur_next.sleepLeft = sleepCycles(cur_reg.activeCfg[`CFG_SLEEP_HI:`CFG_SLEEP_LO]);
					end
					else
					begin
						cur_next.badCnt = cur_reg.badCnt + 3'h1;
						cur_next.validCnt = 4'h0;
					end
				end
				else if (cur_reg.runLen != 16'hffff)
					cur_next.runLen = cur_reg.runLen + 16'h0001;
			end
			POLL_RECEIVE:
			begin
				// no way back to sleep except a new load with auto-poll set
				cur_next.runLen = 16'h0000;
			end
		endcase

		// any committed load re-decides the polling mode from the new word
		if (commit)
		begin
			if (mergedCfg[`CFG_BIT_AUTOPOLL])
			begin
				cur_next.pollState = POLL_SLEEP;
				cur_next.sleepLeft = sleepCycles(mergedCfg[`CFG_SLEEP_HI:`CFG_SLEEP_LO]);
			end
			else
				cur_next.pollState = POLL_AWAKE;
		end

		cur_next.sleepMode = cur_next.pollState == POLL_SLEEP;
		cur_next.checking = cur_next.pollState == POLL_CHECK;
		// while searching or while the pin is released the output is pinned low, otherwise it follows the slicer
		if (cur_next.pollState == POLL_AWAKE || cur_next.pollState == POLL_RECEIVE)
			cur_next.doOut = cur_reg.slicedSync;
		else
			cur_next.doOut = 1'b0;
		if (!cur_next.doOe)
			cur_next.doOut = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_reg <= '0;
			cur_reg.serState <= SER_IDLE;
			cur_reg.pollState <= POLL_AWAKE;
			cur_reg.activeCfg <= `CFG_RESET_VALUE;
			cur_reg.doOe <= 1'b1;
		end
		else
			cur_reg <= cur_next;
	end

	assign dataPinOut = cur_reg.doOut;
	assign dataPinOe = cur_reg.doOe;
	assign configWord = cur_reg.activeCfg;
	assign sleepMode = cur_reg.sleepMode;
	assign checkingBits = cur_reg.checking;
	// the analog controls are wired straight from the committed word flops
	assign agcFastAttackEn = ~cur_reg.activeCfg[`CFG_BIT_AGC_SLOW];
	assign watchdogEn = ~cur_reg.activeCfg[`CFG_BIT_WDOG_OFF];
	assign sliceLevel = cur_reg.activeCfg[`CFG_SLICE_HI:`CFG_SLICE_LO];
	assign highBandwidth = cur_reg.activeCfg[`CFG_BIT_HIGH_BW];
	assign demodBandwidth = cur_reg.activeCfg[`CFG_BW_HI:`CFG_BW_LO];

endmodule

// *** autopoll_checker.sv ***
// assertions on the auto-poll control block, bound onto its top module
// assumes one clock domain and the defines header on the include path
`include "autopoll_defines.svh"
module autopoll_checker #(
	parameter int unsigned SleepBaseCycles = 100
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclkPin,
	input wire logic dataPinOut,
	input wire logic dataPinOe,
	input wire logic [`CFG_WIDTH-1:0] configWord,
	input wire logic sleepMode,
	input wire logic checkingBits,
	input wire logic agcFastAttackEn,
	input wire logic watchdogEn,
	input wire logic [1:0] sliceLevel,
	input wire logic highBandwidth,
	input wire logic [1:0] demodBandwidth
);
	logic [31:0] sleepCnt_reg;
	logic [31:0] sleepLen;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	assign sleepLen = SleepBaseCycles << configWord[14:12];
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			sleepCnt_reg <= '0;
		else
			sleepCnt_reg <= sleepMode ? sleepCnt_reg + 32'h1 : '0;
	a_pin_release: assert property ($rose(sclkPin) && dataPinOe |-> ##[1:4] !dataPinOe)
		else $error("data pin still driven");
	a_search_low: assert property (sleepMode || checkingBits |-> !dataPinOut)
		else $error("data out not low while searching");
	a_one_state: assert property (!(sleepMode && checkingBits))
		else $error("sleep and check together");
	a_agc_map: assert property (agcFastAttackEn == !configWord[19] && watchdogEn == !configWord[18])
		else $error("agc or watchdog enable wrong");
	a_field_map: assert property (sliceLevel == configWord[6:5] && highBandwidth == configWord[16]
		&& demodBandwidth == configWord[4:3])
		else $error("decoded field wrong");
	a_cfg_serial: assert property (!$stable(configWord) |-> !dataPinOe)
		else $error("word changed outside a load");
	a_stay_recv: assert property (!sleepMode && !checkingBits && dataPinOe |=> !sleepMode && !checkingBits)
		else $error("left receive on its own");
	a_wake_check: assert property ($fell(sleepMode) && dataPinOe |-> checkingBits)
		else $error("sleep did not end in checking");
	a_sleep_len: assert property ($fell(sleepMode) && dataPinOe |-> sleepCnt_reg + 32'h2 >= sleepLen
		&& sleepCnt_reg <= sleepLen + 32'h2)
		else $error("sleep length wrong");
	a_bad_sleep: assert property ($rose(sleepMode) && dataPinOe |-> $past(checkingBits))
		else $error("sleep entered not from checking");
endmodule
bind autopoll_bitcheck_serial_config autopoll_checker #(.SleepBaseCycles(SleepBaseCycles)) chk_u (
	.clk(clk), .rst_n(rst_n), .sclkPin(sclkPin), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe),
	.configWord(configWord), .sleepMode(sleepMode), .checkingBits(checkingBits),
	.agcFastAttackEn(agcFastAttackEn), .watchdogEn(watchdogEn), .sliceLevel(sliceLevel),
	.highBandwidth(highBandwidth), .demodBandwidth(demodBandwidth));

// *** autopoll_host.sv ***
// host model that loads the configuration word over the two-wire link
// assumes the bench resolves the shared data pin from en and dat
module autopoll_host (
	input wire logic clk,
	input wire logic dataPinOe,
	output logic sclkPin,
	output logic en,
	output logic dat
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		sclkPin = 1'b0;
		en = 1'b0;
		dat = 1'b0;
	end
	// four core clocks a step: half of a 200 ns serial clock
	task automatic step(input logic c, input logic d);
		@(negedge clk);
		sclkPin = c;
		dat = d;
		repeat (3) @(negedge clk);
	endtask
	task automatic load(input logic [19:0] v, input int n, input bit stop);
		int i;
		step(1'b1, 1'b0);
		en = !dataPinOe;
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		for (i = n - 1; i >= 0; i--)
		begin
			step(1'b0, v[i]);
			step(1'b1, v[i]);
		end
		if (stop)
		begin
			// a last bit of one must drop first, the stop needs a rising data edge
			step(1'b1, 1'b0);
			step(1'b1, 1'b1);
			step(1'b1, 1'b0);
		end
		// release together with the clock fall so no stray edge lands while high
		@(negedge clk);
		sclkPin = 1'b0;
		en = 1'b0;
		repeat (3) @(negedge clk);
	endtask
endmodule

// *** autopoll_bitcheck_serial_config_test.sv ***
// bench for the auto-poll block: serial loads, aborted load, auto-poll cycle
// assumes the host model and the bound checker are compiled alongside
module autopoll_bitcheck_serial_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sliced = 1'b0;
	logic lastWire = 1'b0;
	logic dataWire, dataPinOut, dataPinOe, sleepMode, checkingBits, agc, wdog, highBw;
	logic sclkPin, hostEn, hostDat;
	logic [1:0] slice, bw;
	logic [19:0] cfg;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	localparam logic [19:0] Word = 20'h40e98;
	localparam logic [19:0] Poll = 20'h48ef8;
	always #12.5 clk = ~clk;
	// a released pin shows a changing pattern, never a held value
	assign dataWire = dataPinOe ? dataPinOut : (hostEn ? hostDat : ~lastWire);
	always @(posedge clk) lastWire <= dataWire;
	autopoll_host host_u (.clk(clk), .dataPinOe(dataPinOe), .sclkPin(sclkPin), .en(hostEn),
		.dat(hostDat));
	autopoll_bitcheck_serial_config #(.SleepBaseCycles(100), .SclkTimeoutCycles(200)) dut_u (
		.clk(clk), .rst_n(rst_n), .sclkPin(sclkPin), .dataPinIn(dataWire), .dataPinOut(dataPinOut),
		.dataPinOe(dataPinOe), .slicedData(sliced), .configWord(cfg), .sleepMode(sleepMode),
		.checkingBits(checkingBits), .agcFastAttackEn(agc), .watchdogEn(wdog), .sliceLevel(slice),
		.highBandwidth(highBw), .demodBandwidth(bw));
	task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string msg);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic waitFor(input bit check);
		int i;
		for (i = 0; i < 300 && (check ? checkingBits : sleepMode) !== 1'b1; i++)
			@(negedge clk);
	endtask
	task automatic runs(input int n, input int len);
		repeat (n)
		begin
			repeat (len) @(negedge clk);
			sliced = ~sliced;
		end
		repeat (8) @(negedge clk);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		chk(cfg, 20'h02e78, "reset word");
		chk({14'h0, agc, wdog, slice, bw}, 20'h0003f, "reset outputs");
		host_u.load(Word, 20, 1'b1);
		chk(cfg, Word, "full load");
		chk({15'h0, agc, wdog, slice, highBw}, {15'h0, ~Word[19], ~Word[18], Word[6:5], Word[16]},
			"decoded fields");
		host_u.load(20'h00005, 2, 1'b0);
		repeat (300) @(negedge clk);
		chk(cfg, Word, "aborted load");
		host_u.load(20'h00005, 3, 1'b1);
		chk(cfg, {Word[19:3], 3'h5}, "short load");
		host_u.load(Poll, 20, 1'b1);
		chk({18'h0, sleepMode, dataPinOut}, 20'h2, "poll sleeps");
		waitFor(1'b1);
		chk({19'h0, checkingBits}, 20'h1, "poll checks");
		runs(4, 10);
		chk({18'h0, sleepMode, dataPinOut}, 20'h2, "bad bits sleep");
		waitFor(1'b1);
		// the poll word asks for two valid bits; each run is longer than the window
		runs(8, 1600);
		chk({18'h0, sleepMode, checkingBits}, 20'h0, "valid bits release");
		runs(1, 8);
		chk({19'h0, dataPinOut}, {19'h0, sliced}, "data follows");
		end_of_test();
	end
endmodule
